/* src/acr_consts.svh */
// register offsets, field positions and reset values of the coder host registers
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// host register byte addresses
`define ACR_OFS_LINES_LO 4'h8
`define ACR_OFS_LINES_HI 4'h9
`define ACR_OFS_CTX_BUF 4'ha
`define ACR_OFS_OP_MODE 4'hb
`define ACR_OFS_MARKER 4'hc

// operation mode register fields
`define ACR_MODE_OP_LSB 0
`define ACR_MODE_OP_MSB 1
`define ACR_MODE_LOAD_BIT 2
`define ACR_MODE_STORE_BIT 3
`define ACR_MODE_SKIP_LSB 4
`define ACR_MODE_SKIP_MSB 5
`define ACR_MODE_LI_BIT 6
`define ACR_MODE_TP_BIT 7

// context entry fields
`define ACR_CTX_SYM_BIT 15
`define ACR_CTX_PROB_MSB 14

// reset values
`define ACR_MODE_RST 8'h00
`define ACR_MARK_RST 8'h00
`define ACR_LINES_RST 16'h0000

// sizes and limits
`define ACR_CTX_AW 10
`define ACR_CTX_DEPTH 1024
`define ACR_LINE_MAX 16'hffff

`endif

/* src/acr_ctx_ram.sv */
// context table memory, one write port and one registered read port
`timescale 1ns/1ns
`default_nettype none
`include "acr_consts.svh"

module acr_ctx_ram (
   input wire logic core_clk,
   input wire logic wr_en,
   input wire logic [`ACR_CTX_AW-1:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [`ACR_CTX_AW-1:0] rd_addr,
   output logic [15:0] rd_data
);

   logic [15:0] mem [0:`ACR_CTX_DEPTH-1];

   // write port
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read data comes out of a register
   always_ff @(posedge core_clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule
`default_nettype wire

/* src/acr_pkg.sv */
// types shared by the coder host register files
package acr_pkg;

   // operation mode selection, in the encoding of the mode field
   typedef enum logic [1:0] {
      ACR_OP_CODE,
      ACR_OP_DECODE,
      ACR_OP_THRU_IMG2CODE,
      ACR_OP_THRU_CODE2IMG
   } acr_op_t;

   // processing run state
   typedef enum logic [1:0] {
      ACR_ST_IDLE,
      ACR_ST_RUN,
      ACR_ST_HALTED
   } acr_proc_st_t;

endpackage

/* src/acr_regs.sv */
// host control and status registers of the binary image arithmetic coder
`timescale 1ns/1ns
`default_nettype none
`include "acr_consts.svh"

module acr_regs
   import acr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] host_addr,
   input wire logic host_cs_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic [7:0] host_din,
   output logic [7:0] host_dout,
   output logic host_dout_oe,
   output logic host_wait,
   input wire logic sys_hw_reset,
   input wire logic proc_start,
   input wire logic first_stripe_start,
   input wire logic ctx_xfer_start,
   input wire logic stop_kind_select,
   input wire logic [15:0] line_count_set,
   input wire logic line_done,
   input wire logic ram_busy,
   input wire logic code_byte_valid,
   input wire logic marker_found,
   input wire logic [7:0] marker_byte,
   output logic proc_running,
   output logic proc_halt,
   output logic halt_is_temp,
   output logic start_refused,
   output logic end_marker_append,
   output logic [7:0] end_marker_byte,
   output logic [1:0] op_select,
   output logic [1:0] linemem_xfer_select,
   output logic load_from_image,
   output logic load_from_code,
   output logic store_to_code,
   output logic store_to_image,
   output logic [1:0] head_skip_count,
   output logic head_discard,
   output logic linemem_init_inhibit,
   output logic linemem_init_req,
   output logic typical_prediction_on
);

   // host strobes and edges
   logic wr_sel;
   logic rd_sel;
   logic wr_sel_reg;
   logic rd_sel_reg;
   logic [3:0] rd_addr_reg;
   logic wr_take;
   logic rd_done;

   // register state
   logic [7:0] mode_reg;
   logic [7:0] marker_set_reg;
   logic [7:0] marker_found_reg;
   logic [15:0] lines_reg;
   acr_proc_st_t st_reg;
   acr_proc_st_t st_next;
   logic halt_reg;
   logic halt_temp_reg;
   logic append_reg;
   logic refused_reg;
   logic [1:0] skip_left_reg;
   logic init_req_reg;
   logic [7:0] dout_reg;

   // context table path
   logic ctx_active_reg;
   logic ctx_phase_hi_reg;
   logic [7:0] ctx_lo_reg;
   logic [`ACR_CTX_AW-1:0] ctx_rd_addr_reg;
   logic [`ACR_CTX_AW-1:0] ctx_wr_addr_reg;
   logic [15:0] ram_q;
   logic buf_wr;
   logic buf_rd_done;

   // two-entry buffer between host word assembly and the memory
   logic [15:0] fifo_mem_reg [0:1];
   logic [1:0] fifo_cnt_reg;
   logic fifo_wptr_reg;
   logic fifo_rptr_reg;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic fifo_push;
   logic fifo_pop;

   // address compare used by both strobe paths
   function automatic logic addr_is(input logic [3:0] a,
                                    input logic [3:0] ofs);
      addr_is = (a == ofs);
   endfunction

   // host strobes: write taken on the first cycle, read effect at release
   assign wr_sel = ~host_cs_n & ~host_wr_n;
   assign rd_sel = ~host_cs_n & ~host_rd_n;
   assign wr_take = wr_sel & ~wr_sel_reg;
   assign rd_done = rd_sel_reg & ~rd_sel;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_sel_reg <= 1'b0;
         rd_sel_reg <= 1'b0;
         rd_addr_reg <= 4'h0;
      end else begin
         wr_sel_reg <= wr_sel;
         rd_sel_reg <= rd_sel;
         rd_addr_reg <= host_addr;
      end
   end

   // operation mode register, cleared by either hardware reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_reg <= `ACR_MODE_RST;
      end else if (sys_hw_reset) begin
         mode_reg <= `ACR_MODE_RST;
      end else if (wr_take && addr_is(host_addr, `ACR_OFS_OP_MODE)) begin
         mode_reg <= host_din;
      end
   end

   // mode decode
   assign op_select = mode_reg[`ACR_MODE_OP_MSB:`ACR_MODE_OP_LSB];
   assign linemem_xfer_select = mode_reg[`ACR_MODE_OP_MSB] ?
      mode_reg[`ACR_MODE_STORE_BIT:`ACR_MODE_LOAD_BIT] : 2'b00;
   assign load_from_image = (op_select == ACR_OP_THRU_IMG2CODE) &
      linemem_xfer_select[0];
   assign store_to_code = (op_select == ACR_OP_THRU_IMG2CODE) &
      linemem_xfer_select[1];
   assign load_from_code = (op_select == ACR_OP_THRU_CODE2IMG) &
      linemem_xfer_select[0];
   assign store_to_image = (op_select == ACR_OP_THRU_CODE2IMG) &
      linemem_xfer_select[1];
   assign head_skip_count =
      mode_reg[`ACR_MODE_SKIP_MSB:`ACR_MODE_SKIP_LSB];
   assign linemem_init_inhibit = mode_reg[`ACR_MODE_LI_BIT];
   assign typical_prediction_on = mode_reg[`ACR_MODE_TP_BIT] &
      ~mode_reg[`ACR_MODE_OP_MSB];

   // end marker setup register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         marker_set_reg <= `ACR_MARK_RST;
      end else if (sys_hw_reset) begin
         marker_set_reg <= `ACR_MARK_RST;
      end else if (wr_take && addr_is(host_addr, `ACR_OFS_MARKER)) begin
         marker_set_reg <= host_din;
      end
   end
   assign end_marker_byte = marker_set_reg;

   // detected marker capture while decoding
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         marker_found_reg <= `ACR_MARK_RST;
      end else if (sys_hw_reset) begin
         marker_found_reg <= `ACR_MARK_RST;
      end else if (marker_found && op_select == ACR_OP_DECODE) begin
         marker_found_reg <= marker_byte;
      end
   end

   // processing run state
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ACR_ST_IDLE, ACR_ST_HALTED: begin
            if (proc_start && line_count_set != 16'h0000) begin
               st_next = ACR_ST_RUN;
            end
         end
         ACR_ST_RUN: begin
            if (lines_reg >= line_count_set) begin
               st_next = ACR_ST_HALTED;
            end
         end
         default: begin
            st_next = ACR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg <= ACR_ST_IDLE;
      end else if (sys_hw_reset) begin
         st_reg <= ACR_ST_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end
   assign proc_running = (st_reg == ACR_ST_RUN);

   // halt pulse, stop kind and end marker request
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         halt_reg <= 1'b0;
         halt_temp_reg <= 1'b0;
         append_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         halt_reg <= proc_running & (st_next == ACR_ST_HALTED);
         append_reg <= proc_running & (st_next == ACR_ST_HALTED) &
            ~stop_kind_select & (op_select == ACR_OP_CODE);
         refused_reg <= proc_start & (line_count_set == 16'h0000);
         if (proc_running && st_next == ACR_ST_HALTED) begin
            halt_temp_reg <= stop_kind_select;
         end
      end
   end
   assign proc_halt = halt_reg;
   assign halt_is_temp = halt_temp_reg;
   assign end_marker_append = append_reg;
   assign start_refused = refused_reg;

   // processed line counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lines_reg <= `ACR_LINES_RST;
      end else if (sys_hw_reset || proc_start) begin
         lines_reg <= `ACR_LINES_RST;
      end else if (line_done && proc_running &&
                   lines_reg != `ACR_LINE_MAX) begin
         lines_reg <= lines_reg + 16'h0001;
      end
   end

   // head byte discard at first stripe decode start
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         skip_left_reg <= 2'b00;
      end else if (sys_hw_reset) begin
         skip_left_reg <= 2'b00;
      end else if (first_stripe_start && op_select == ACR_OP_DECODE) begin
         skip_left_reg <= head_skip_count;
      end else if (head_discard) begin
         skip_left_reg <= skip_left_reg - 2'b01;
      end
   end
   assign head_discard = (skip_left_reg != 2'b00) & code_byte_valid;

   // line memory initialization request
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         init_req_reg <= 1'b1;
      end else begin
         init_req_reg <= sys_hw_reset | (first_stripe_start &
            ~linemem_init_inhibit & ~mode_reg[`ACR_MODE_OP_MSB]);
      end
   end
   assign linemem_init_req = init_req_reg;

   // context transfer window and byte phase
   assign buf_wr = wr_take & addr_is(host_addr, `ACR_OFS_CTX_BUF) &
      ctx_active_reg;
   assign buf_rd_done = rd_done & addr_is(rd_addr_reg, `ACR_OFS_CTX_BUF) &
      ctx_active_reg;
   assign fifo_in_valid = buf_wr & ctx_phase_hi_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctx_active_reg <= 1'b0;
         ctx_phase_hi_reg <= 1'b0;
         ctx_lo_reg <= 8'h00;
         ctx_rd_addr_reg <= '0;
      end else if (sys_hw_reset || proc_start) begin
         ctx_active_reg <= 1'b0;
         ctx_phase_hi_reg <= 1'b0;
      end else if (ctx_xfer_start) begin
         ctx_active_reg <= 1'b1;
         ctx_phase_hi_reg <= 1'b0;
         ctx_rd_addr_reg <= '0;
      end else if (buf_wr && !ctx_phase_hi_reg) begin
         ctx_lo_reg <= host_din;
         ctx_phase_hi_reg <= 1'b1;
      end else if (buf_wr && fifo_in_ready) begin
         ctx_phase_hi_reg <= 1'b0;
      end else if (buf_rd_done) begin
         ctx_phase_hi_reg <= ~ctx_phase_hi_reg;
         if (ctx_phase_hi_reg) begin
            ctx_rd_addr_reg <= ctx_rd_addr_reg + 1'b1;
         end
      end
   end

   // two-entry buffer; the memory stalls it while the core holds the RAM
   assign fifo_in_ready = (fifo_cnt_reg != 2'd2);
   assign fifo_out_valid = (fifo_cnt_reg != 2'd0);
   assign fifo_out_ready = ~ram_busy;
   assign fifo_push = fifo_in_valid & fifo_in_ready;
   assign fifo_pop = fifo_out_valid & fifo_out_ready;
   assign host_wait = buf_wr & ctx_phase_hi_reg & ~fifo_in_ready;

   always_ff @(posedge core_clk) begin
      if (fifo_push) begin
         fifo_mem_reg[fifo_wptr_reg] <= {host_din, ctx_lo_reg};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fifo_cnt_reg <= 2'd0;
         fifo_wptr_reg <= 1'b0;
         fifo_rptr_reg <= 1'b0;
      end else begin
         if (fifo_push) begin
            fifo_wptr_reg <= ~fifo_wptr_reg;
         end
         if (fifo_pop) begin
            fifo_rptr_reg <= ~fifo_rptr_reg;
         end
         case ({fifo_push, fifo_pop})
            2'b10: fifo_cnt_reg <= fifo_cnt_reg + 2'd1;
            2'b01: fifo_cnt_reg <= fifo_cnt_reg - 2'd1;
            default: fifo_cnt_reg <= fifo_cnt_reg;
         endcase
      end
   end

   // load address follows the drained words
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctx_wr_addr_reg <= '0;
      end else if (ctx_xfer_start) begin
         ctx_wr_addr_reg <= '0;
      end else if (fifo_pop) begin
         ctx_wr_addr_reg <= ctx_wr_addr_reg + 1'b1;
      end
   end

   acr_ctx_ram u_ctx_ram (
      .core_clk(core_clk),
      .wr_en(fifo_pop),
      .wr_addr(ctx_wr_addr_reg),
      .wr_data(fifo_mem_reg[fifo_rptr_reg]),
      .rd_addr(ctx_rd_addr_reg),
      .rd_data(ram_q)
   );

   // registered read data
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dout_reg <= 8'h00;
      end else begin
         case (host_addr)
            `ACR_OFS_LINES_LO: dout_reg <= lines_reg[7:0];
            `ACR_OFS_LINES_HI: dout_reg <= lines_reg[15:8];
            `ACR_OFS_OP_MODE: dout_reg <= mode_reg;
            `ACR_OFS_MARKER: dout_reg <= marker_found_reg;
            `ACR_OFS_CTX_BUF: begin
               if (!ctx_active_reg) begin
                  dout_reg <= 8'h00;
               end else if (ctx_phase_hi_reg) begin
                  dout_reg <= ram_q[15:8];
               end else begin
                  dout_reg <= ram_q[7:0];
               end
            end
            default: dout_reg <= 8'h00;
         endcase
      end
   end
   assign host_dout = dout_reg;
   assign host_dout_oe = rd_sel;

endmodule
`default_nettype wire

/* verif/acr_host_bfm.sv */
// host processor bus model for the coder register port
`timescale 1ns/1ns
`default_nettype none
`include "acr_consts.svh"
module acr_host_bfm (
   output logic [3:0] host_addr,
   output logic host_cs_n,
   output logic host_rd_n,
   output logic host_wr_n,
   output logic [7:0] host_din,
   input wire logic core_clk,
   input wire logic [7:0] host_dout,
   input wire logic host_wait
);
   // idle bus at time zero
   initial begin
      host_addr = 4'h0;
      {host_cs_n, host_rd_n, host_wr_n} = 3'b111;
      host_din = 8'h5a;
   end
   // one write strobe, repeated while the buffer refuses it
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic refused;
      refused = 1'b1;
      while (refused) begin
         host_addr <= a;
         host_din <= d;
         {host_cs_n, host_wr_n} <= 2'b00;
         @(posedge core_clk);
         refused = host_wait;
         {host_cs_n, host_wr_n} <= 2'b11;
         host_din <= ~d; // released data must not look valid
         @(posedge core_clk);
      end
   endtask
   // read strobe held two edges; gap lets the memory fetch the next word
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      host_addr <= a;
      {host_cs_n, host_rd_n} <= 2'b00;
      repeat (2) @(posedge core_clk);
      d = host_dout;
      {host_cs_n, host_rd_n} <= 2'b11;
      repeat (3) @(posedge core_clk);
   endtask
   // a context word moves low byte first, then high byte
   task automatic wr_word(input logic [15:0] w);
      wr(`ACR_OFS_CTX_BUF, w[7:0]);
      wr(`ACR_OFS_CTX_BUF, w[15:8]);
   endtask
   task automatic rd_word(output logic [15:0] w);
      rd(`ACR_OFS_CTX_BUF, w[7:0]);
      rd(`ACR_OFS_CTX_BUF, w[15:8]);
   endtask
endmodule
`default_nettype wire

/* verif/acr_regs_chk.sv */
// concurrent checks on the coder host register ports
`timescale 1ns/1ns
`default_nettype none
`include "acr_consts.svh"
module acr_regs_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] host_addr,
   input wire logic host_cs_n,
   input wire logic host_wr_n,
   input wire logic host_wait,
   input wire logic sys_hw_reset,
   input wire logic proc_start,
   input wire logic [15:0] line_count_set,
   input wire logic proc_running,
   input wire logic proc_halt,
   input wire logic halt_is_temp,
   input wire logic start_refused,
   input wire logic end_marker_append,
   input wire logic [1:0] op_select,
   input wire logic [1:0] linemem_xfer_select,
   input wire logic load_from_image,
   input wire logic store_to_image,
   input wire logic typical_prediction_on,
   input wire logic linemem_init_req,
   input wire logic linemem_init_inhibit
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_xfer_gate:
      assert property (!op_select[1] |-> linemem_xfer_select == 2'b00)
      else $error("line memory transfer outside through mode");
   chk_load_dir:
      assert property (load_from_image |->
         op_select == 2'b10 && linemem_xfer_select[0])
      else $error("image side load in wrong mode");
   chk_store_dir:
      assert property (store_to_image |->
         op_select == 2'b11 && linemem_xfer_select[1])
      else $error("image side store in wrong mode");
   chk_tp_gate:
      assert property (op_select[1] |-> !typical_prediction_on)
      else $error("typical prediction on in through mode");
   chk_halt_pulse:
      assert property (proc_halt |->
         !proc_running && $past(proc_running) ##1 !proc_halt)
      else $error("halt pulse without a run ending");
   chk_start_run:
      assert property (proc_start && !proc_running && !sys_hw_reset &&
         line_count_set != 16'h0000 |=> proc_running && !start_refused)
      else $error("start with a count did not run");
   chk_zero_refuse:
      assert property (proc_start && !sys_hw_reset &&
         line_count_set == 16'h0000 |=> start_refused && $stable(proc_running))
      else $error("zero line count not refused");
   chk_marker_end:
      assert property (end_marker_append |->
         proc_halt && !halt_is_temp && op_select == 2'b00)
      else $error("end marker outside final coding end");
   chk_init_clear:
      assert property (sys_hw_reset |=>
         linemem_init_req && !linemem_init_inhibit && op_select == 2'b00)
      else $error("hardware reset did not clear mode");
   chk_wait_write:
      assert property (host_wait |-> !host_cs_n && !host_wr_n &&
         host_addr == `ACR_OFS_CTX_BUF)
      else $error("wait raised outside a buffer write");
endmodule
bind acr_regs acr_regs_chk u_chk (.core_clk, .rst, .host_addr, .host_cs_n,
   .host_wr_n, .host_wait, .sys_hw_reset, .proc_start, .line_count_set,
   .proc_running, .proc_halt, .halt_is_temp, .start_refused,
   .end_marker_append, .op_select, .linemem_xfer_select, .load_from_image,
   .store_to_image, .typical_prediction_on, .linemem_init_req,
   .linemem_init_inhibit);
`default_nettype wire

/* verif/acr_regs_tb.sv */
// self-checking bench for the coder host register block
`timescale 1ns/1ns
`default_nettype none
module acr_regs_tb;
   logic core_clk, rst, host_cs_n, host_rd_n, host_wr_n, host_dout_oe;
   logic host_wait, sys_hw_reset, proc_start, first_stripe_start;
   logic ctx_xfer_start, stop_kind_select, line_done, ram_busy, busy_on;
   logic code_byte_valid, marker_found, proc_running, proc_halt;
   logic halt_is_temp, start_refused, end_marker_append, head_discard;
   logic load_from_image, load_from_code, store_to_code, store_to_image;
   logic linemem_init_inhibit, linemem_init_req, typical_prediction_on;
   logic [1:0] op_select, linemem_xfer_select, head_skip_count;
   logic [3:0] host_addr;
   logic [7:0] host_din, host_dout, marker_byte, end_marker_byte, v, m;
   logic [15:0] line_count_set, w, n;
   logic [15:0] wexp [6];
   logic [3:0] ofs [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h0};
   int failures, n_compared, cycles, n_halt, n_app, n_ref, n_disc, n_init;

   acr_regs u_dut (.*);
   acr_host_bfm u_host (.*);

   // clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // event counters, memory stalls and the hang limit
   always @(posedge core_clk) begin
      cycles++;
      n_halt += proc_halt;
      n_app += end_marker_append;
      n_ref += start_refused;
      n_init += linemem_init_req;
      n_disc += head_discard;
      chk("read enable", host_dout_oe, !host_cs_n && !host_rd_n);
      ram_busy <= busy_on && ($urandom % 4 != 0);
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic chk(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (failures == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one-cycle command pulses: start, stripe, context, hw reset, line,
   // marker, code byte
   task automatic fire(input logic [6:0] c);
      {proc_start, first_stripe_start, ctx_xfer_start, sys_hw_reset,
         line_done, marker_found, code_byte_valid} <= c;
      @(posedge core_clk);
      {proc_start, first_stripe_start, ctx_xfer_start, sys_hw_reset,
         line_done, marker_found, code_byte_valid} <= 7'h00;
      @(posedge core_clk);
   endtask
   // mode pins expected from a mode register value
   function automatic logic [11:0] exp_mode(input logic [7:0] a);
      return {a[1:0], a[1] ? a[3:2] : 2'b00, a[1:0] == 2'b10 && a[2],
         a[1:0] == 2'b11 && a[2], a[1:0] == 2'b10 && a[3],
         a[1:0] == 2'b11 && a[3], a[5:4], a[6], a[7] & ~a[1]};
   endfunction

   initial begin
      void'($urandom(32'hc34bd5f3));
      {rst, busy_on, stop_kind_select} = 3'b100;
      {proc_start, first_stripe_start, ctx_xfer_start, sys_hw_reset,
         line_done, marker_found, code_byte_valid} = 7'h00;
      line_count_set = 16'h0001;
      marker_byte = 8'h00;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // reset values, closed buffer window and an unmapped place
      foreach (ofs[i]) begin
         u_host.rd(ofs[i], v);
         chk("reset read", v, 16'h0000);
      end
      // every op code and transfer direction, random side fields
      for (int i = 0; i < 8; i++) begin
         m = 8'($urandom);
         m[3:0] = {i[2] ? 2'b10 : 2'b01, i[1:0]};
         u_host.wr(4'hb, m);
         u_host.rd(4'hb, v);
         chk("mode reg", v, m);
         chk("mode pins", {op_select, linemem_xfer_select,
            load_from_image, load_from_code, store_to_code, store_to_image,
            head_skip_count, linemem_init_inhibit, typical_prediction_on},
            exp_mode(m));
      end
      // context words written under memory stalls, then read back
      busy_on = 1'b1;
      fire(7'h10);
      for (int i = 0; i < 6; i++) begin
         wexp[i] = {1'($urandom), 15'($urandom_range(23314, 1))};
         u_host.wr_word(wexp[i]);
      end
      busy_on = 1'b0;
      repeat (6) @(posedge core_clk);
      fire(7'h10);
      for (int i = 0; i < 6; i++) begin
         u_host.rd_word(w);
         chk("context word", w, wexp[i]);
      end
      // runs to the set count in coding and decoding, both stop kinds
      u_host.wr(4'hc, 8'h02);
      // the fifth run is a two-line line memory load from the image side
      for (int i = 0; i < 5; i++) begin
         n = (i == 4) ? 16'h0002 : 16'($urandom_range(4, 1));
         u_host.wr(4'hb, (i == 4) ? 8'h06 : {7'h00, i[1]});
         stop_kind_select <= i[0];
         line_count_set <= n;
         n_halt = 0;
         n_app = 0;
         fire(7'h40);
         u_host.rd(4'h8, v);
         chk("lines cleared", v, 16'h0000);
         repeat (n) fire(7'h04);
         repeat (2) @(posedge core_clk);
         chk("halts", n_halt, 1);
         chk("end marker", n_app, i == 0);
         chk("stop kind", halt_is_temp, i[0]);
         chk("load source", load_from_image, i == 4);
         chk("marker setup", end_marker_byte, 8'h02);
         u_host.rd(4'h8, v);
         chk("lines low", v, n);
         u_host.rd(4'h9, v);
         chk("lines high", v, 16'h0000);
      end
      // back to decoding so that the found marker is captured
      u_host.wr(4'hb, 8'h01);
      marker_byte <= 8'h04;
      fire(7'h02);
      u_host.rd(4'hc, v);
      chk("found marker", v, 8'h04);
      line_count_set <= 16'h0000;
      n_ref = 0;
      fire(7'h40);
      repeat (2) @(posedge core_clk);
      chk("refused", n_ref, 1);
      // head byte skipping and line memory init at first stripe starts
      for (int i = 0; i < 4; i++) begin
         m = {1'b0, 1'($urandom), i[1:0], 4'b0001};
         u_host.wr(4'hb, m);
         line_count_set <= 16'h0001;
         n_disc = 0;
         n_init = 0;
         fire(7'h60);
         repeat (4) fire(7'h01);
         chk("head discards", n_disc, i);
         fire(7'h08);
         repeat (2) @(posedge core_clk);
         chk("init requests", n_init, 2 - m[6]);
         u_host.rd(4'hb, v);
         chk("mode after reset", v, 8'h00);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
